// >>> src/tws_pkg.sv
// Shared constants and carriers for the two-wire slave-transmitter status block.
// Assumes a system clock domain for software and a separate link sampling clock.
package tws_pkg;
   localparam logic [7:0] CODE_OWN_READ = 8'hA8;
   localparam logic [7:0] CODE_LOST_READ = 8'hB0;
   localparam logic [7:0] CODE_TX_ACK = 8'hB8;
   localparam logic [7:0] CODE_TX_NACK = 8'hC0;
   localparam logic [7:0] CODE_LAST_ACK = 8'hC8;
   localparam logic [7:0] CODE_IDLE = 8'hF8;
   localparam logic [7:0] CODE_BUS_ERROR = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'hFF;
   localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
   localparam int CODE_FIELD_LSB = 3;

   // Control bits as software writes and reads them
   typedef struct packed {
      logic job_done_flag;
      logic ack_enable;
      logic start_request;
      logic stop_request;
      logic enable;
      logic general_call_enable;
   } tws_ctrl_s;

   localparam tws_ctrl_s CTRL_RESET = '{default: 1'b0};

   // Open-drain pin as two signals
   typedef struct packed {
      logic out;
      logic oe_n;
   } tws_pin_s;
endpackage : tws_pkg

// >>> src/tws_slave_tx.sv
// Two-wire slave-transmitter status sequencer with software control and status ports.
// Assumes free-running link_clk oversamples the bus pins; clk carries software side.
//
// Functional notes
// RL1 - Own address with read bit acknowledged: set flag, report 0xA8.
// RL2 - Lost arbitration then addressed for read: report 0xB0.
// RL3 - Byte sent and master acknowledged: report 0xB8.
// RL4 - Byte sent and master not acknowledged: report 0xC0.
// RL5 - Final byte sent but master acknowledged: report 0xC8.
// RL6 - In 0xA8/0xB0/0xB8 software loads byte; ack_enable selects final or not.
// RL7 - Leaving 0xC0/0xC8 with ack_enable low: unaddressed, ignore all addresses.
// RL8 - Leaving with ack_enable high: own address recognised, general call if enabled.
// RL9 - Start request on leaving 0xC0/0xC8: issue START when bus free.
// RL10 - Flag clear means status 0xF8.
// RL11 - START or STOP inside a frame is a bus error, status 0x00.
// RL12 - Bus error sets the flag.
// RL13 - Stop request plus flag clear recovers; hardware clears stop request.
// RL14 - Recovery releases both lines and sends no STOP.
// RL15 - Software masks prescaler bits before comparing status codes.
// RL16 - Repeated START keeps bus ownership for direction change.
// RL17 - Software keeps write-address then read sequence atomic.
// RL18 - After final byte the device ignores clocking; master reads ones.
// RL19 - Flag set while continuing a transfer stretches SCL low.
// RL20 - Status code sits in bits seven down to three.
`timescale 1ns/1ps
`default_nettype none

module tws_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1, s2, s3;
   logic [W-1:0] next_q;
   if (W < 1) begin : g_bad_width
      $error("tws_sync needs a positive width");
   end
   always_comb begin
      // A bit is accepted only once two later stages agree
      next_q = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & q);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         q <= INIT;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q <= next_q;
      end
   end
endmodule : tws_sync

module tws_slave_tx (
   // System clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Link sampling clock
   input wire logic link_clk,
   // Software control
   input wire logic ctrl_wr,
   input wire tws_pkg::tws_ctrl_s ctrl_wdata,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   input wire logic [6:0] own_slave_addr,
   // Master-side hooks
   input wire logic arb_lost,
   input wire logic master_active,
   // Software status
   output tws_pkg::tws_ctrl_s ctrl_rd,
   output logic [7:0] state_code_reg,
   output logic write_collision,
   output logic start_go,
   // Bus pins
   input wire logic scl_in,
   output tws_pkg::tws_pin_s scl_pin,
   input wire logic sda_in,
   output tws_pkg::tws_pin_s sda_pin
);
   typedef enum {L_IDLE, L_ADDR, L_AACK, L_TX, L_RACK, L_WAIT, L_IGNORE} tws_link_e;

   // Reset release per domain
   logic srst_a, srst_n, lrst_a, lrst_n;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         srst_a <= 1'b0;
         srst_n <= 1'b0;
      end else begin
         srst_a <= 1'b1;
         srst_n <= srst_a;
      end
   end
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         lrst_a <= 1'b0;
         lrst_n <= 1'b0;
      end else begin
         lrst_a <= 1'b1;
         lrst_n <= lrst_a;
      end
   end

   // Cross-domain state
   logic ev_tog, busy, rel_tog, rel_ack;
   logic [7:0] lk_code, shift_data_reg;
   logic ev_s, busy_s;
   tws_sync #(.W(2), .INIT(2'b00)) u_sys_sync (
      .clk(clk), .rst_n(srst_n), .d({ev_tog, busy}), .q({ev_s, busy_s}));

   logic f_scl, f_sda, ack_l, en_l, gce_l, rel_s;
   logic [6:0] own_l;
   tws_sync #(.W(13), .INIT(13'h1800)) u_link_sync (
      .clk(link_clk), .rst_n(lrst_n),
      .d({scl_in, sda_in, ctrl_rd.ack_enable, ctrl_rd.enable, ctrl_rd.general_call_enable, own_slave_addr, rel_tog}),
      .q({f_scl, f_sda, ack_l, en_l, gce_l, own_l, rel_s}));

   // ---------------- System domain ----------------
   logic ev_seen, lost_pend, start_pend;
   logic next_ev_seen, next_lost_pend, next_start_pend, next_start_go, next_rel_tog, next_rel_ack, next_wcol;
   logic [7:0] code, next_code, next_state_code, next_data;
   tws_pkg::tws_ctrl_s next_ctrl;
   logic ev, clr;
   assign ev = ev_s != ev_seen;
   assign clr = ctrl_wr && ctrl_wdata.job_done_flag && ctrl_rd.job_done_flag;

   always_comb begin
      next_ev_seen = ev_s;
      next_code = code;
      next_lost_pend = lost_pend | arb_lost;
      next_start_pend = start_pend;
      next_start_go = 1'b0;
      next_rel_tog = rel_tog;
      next_rel_ack = rel_ack;
      next_data = shift_data_reg;
      next_wcol = write_collision;
      next_ctrl = ctrl_rd;
      if (ctrl_wr) begin
         next_ctrl.ack_enable = ctrl_wdata.ack_enable;
         next_ctrl.start_request = ctrl_wdata.start_request;
         next_ctrl.stop_request = ctrl_wdata.stop_request;
         next_ctrl.enable = ctrl_wdata.enable;
         next_ctrl.general_call_enable = ctrl_wdata.general_call_enable;
      end
      if (clr) begin
         next_ctrl.job_done_flag = 1'b0;
         next_rel_tog = ~rel_tog;
         next_rel_ack = ctrl_wdata.ack_enable; // RL6
         if (code == tws_pkg::CODE_BUS_ERROR && ctrl_wdata.stop_request) begin
            next_ctrl.stop_request = 1'b0; // RL13
         end
         if ((code == tws_pkg::CODE_TX_NACK || code == tws_pkg::CODE_LAST_ACK) && ctrl_wdata.start_request) begin
            next_start_pend = 1'b1; // RL9
         end
      end
      // Set wins over a clear in the same cycle
      if (ev) begin
         next_ctrl.job_done_flag = 1'b1; // RL12
         next_code = lk_code; // RL11
         if (lk_code == tws_pkg::CODE_OWN_READ && next_lost_pend) begin
            next_code = tws_pkg::CODE_LOST_READ; // RL2
            next_lost_pend = 1'b0;
         end
      end
      // Repeated START while already master needs no free bus
      if (start_pend && (!busy_s || master_active)) begin
         next_start_go = 1'b1; // RL9 RL16
         next_start_pend = 1'b0;
      end
      // Loads while the flag is low would disturb the byte in flight
      if (data_wr) begin
         next_wcol = !ctrl_rd.job_done_flag;
         if (ctrl_rd.job_done_flag) begin
            next_data = data_wdata;
         end
      end
      next_state_code = next_ctrl.job_done_flag ? next_code : tws_pkg::CODE_IDLE; // RL10 RL20
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         ev_seen <= 1'b0;
         code <= tws_pkg::CODE_IDLE;
         lost_pend <= 1'b0;
         start_pend <= 1'b0;
         start_go <= 1'b0;
         rel_tog <= 1'b0;
         rel_ack <= 1'b0;
         shift_data_reg <= tws_pkg::DATA_RESET;
         write_collision <= 1'b0;
         ctrl_rd <= tws_pkg::CTRL_RESET;
         state_code_reg <= tws_pkg::CODE_IDLE;
      end else begin
         ev_seen <= next_ev_seen;
         code <= next_code;
         lost_pend <= next_lost_pend;
         start_pend <= next_start_pend;
         start_go <= next_start_go;
         rel_tog <= next_rel_tog;
         rel_ack <= next_rel_ack;
         shift_data_reg <= next_data;
         write_collision <= next_wcol;
         ctrl_rd <= next_ctrl;
         state_code_reg <= next_state_code;
      end
   end

   a_idle_code: assert property (@(posedge clk) disable iff (!srst_n)
      !ctrl_rd.job_done_flag |-> state_code_reg == tws_pkg::CODE_IDLE) else $error("flag clear but code not idle"); // RL10
   a_event_flag: assert property (@(posedge clk) disable iff (!srst_n)
      ev |=> ctrl_rd.job_done_flag && state_code_reg[2:0] == 3'h0) else $error("event did not set flag"); // RL12
   a_error_code: assert property (@(posedge clk) disable iff (!srst_n)
      ev && lk_code == tws_pkg::CODE_BUS_ERROR |=> state_code_reg == tws_pkg::CODE_BUS_ERROR) else $error("bus error code"); // RL11
   a_lost_code: assert property (@(posedge clk) disable iff (!srst_n)
      ev && lk_code == tws_pkg::CODE_OWN_READ && (lost_pend || arb_lost) |=> state_code_reg == tws_pkg::CODE_LOST_READ)
      else $error("lost arbitration code"); // RL2
   a_own_code: assert property (@(posedge clk) disable iff (!srst_n)
      ev && lk_code == tws_pkg::CODE_OWN_READ && !lost_pend && !arb_lost |=> state_code_reg == tws_pkg::CODE_OWN_READ)
      else $error("own read code"); // RL1
   a_stop_recover: assert property (@(posedge clk) disable iff (!srst_n)
      clr && code == tws_pkg::CODE_BUS_ERROR && ctrl_wdata.stop_request |=> !ctrl_rd.stop_request)
      else $error("stop request not cleared"); // RL13
   a_start_later: assert property (@(posedge clk) disable iff (!srst_n)
      start_go |-> $past(start_pend) && !start_pend) else $error("start without request"); // RL9

   // ---------------- Link domain ----------------
   tws_link_e st, next_st;
   logic [3:0] cnt, next_cnt;
   logic [7:0] shreg, next_shreg, next_lk_code;
   logic p_scl, p_sda, hold, final_byte, txn, ack_seen, rel_seen, sda_oe_n, scl_oe_n;
   logic next_hold, next_final, next_txn, next_ack_seen, next_ev_tog, next_busy, next_sda_oe_n, next_scl_oe_n;
   logic start_c, stop_c, rise, fall, in_frame, rel_ev;
   logic [7:0] abyte;
   assign start_c = p_scl && f_scl && p_sda && !f_sda;
   assign stop_c = p_scl && f_scl && !p_sda && f_sda;
   assign rise = !p_scl && f_scl;
   assign fall = p_scl && !f_scl;
   assign rel_ev = rel_s != rel_seen;
   assign abyte = {shreg[6:0], f_sda};
   assign in_frame = (st == L_ADDR && cnt != 4'h0) || st == L_AACK || st == L_TX || st == L_RACK;

   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_shreg = shreg;
      next_lk_code = lk_code;
      next_hold = hold;
      next_final = final_byte;
      next_txn = txn;
      next_ack_seen = ack_seen;
      next_ev_tog = ev_tog;
      next_sda_oe_n = sda_oe_n;
      next_scl_oe_n = scl_oe_n;
      next_busy = start_c ? 1'b1 : (stop_c ? 1'b0 : busy);
      if (!en_l) begin
         next_st = L_IDLE;
         next_sda_oe_n = 1'b1;
         next_scl_oe_n = 1'b1;
         next_hold = 1'b0;
      end else if ((start_c || stop_c) && in_frame) begin
         next_lk_code = tws_pkg::CODE_BUS_ERROR; // RL11
         next_ev_tog = ~ev_tog;
         next_st = L_WAIT;
         next_hold = 1'b0;
         next_txn = 1'b0;
         next_sda_oe_n = 1'b1; // RL14
         next_scl_oe_n = 1'b1; // RL14
      end else if (start_c && st != L_WAIT) begin
         next_st = L_ADDR;
         next_cnt = 4'h0;
      end else if (stop_c && st != L_WAIT) begin
         next_st = L_IDLE;
      end else begin
         case (st)
            L_ADDR: if (rise) begin
               next_shreg = abyte;
               next_cnt = 4'(cnt + 4'h1);
               if (cnt == 4'h7) begin
                  next_cnt = 4'h0;
                  // Address match only while acknowledging is enabled
                  if (ack_l && abyte[0] && (abyte[7:1] == own_l ||
                      (gce_l && abyte[7:1] == tws_pkg::GENERAL_CALL_ADDR))) begin // RL7 RL8
                     next_st = L_AACK;
                  end else begin
                     next_st = L_IGNORE;
                  end
               end
            end
            L_AACK: begin
               if (cnt == 4'h0 && fall) begin
                  next_sda_oe_n = 1'b0;
                  next_cnt = 4'h1;
               end else if (cnt == 4'h1 && rise) begin
                  next_cnt = 4'h2;
               end else if (cnt == 4'h2 && fall) begin
                  next_sda_oe_n = 1'b1;
                  next_lk_code = tws_pkg::CODE_OWN_READ; // RL1
                  next_ev_tog = ~ev_tog;
                  next_hold = 1'b1; // RL19
                  next_scl_oe_n = 1'b0;
                  next_txn = 1'b1;
                  next_st = L_WAIT;
               end
            end
            L_WAIT: if (rel_ev) begin
               next_hold = 1'b0;
               next_scl_oe_n = 1'b1;
               if (txn) begin
                  next_shreg = shift_data_reg;
                  next_final = !rel_ack; // RL6
                  next_sda_oe_n = shift_data_reg[7];
                  next_cnt = 4'h0;
                  next_st = L_TX;
               end else begin
                  next_st = L_IDLE; // RL7 RL8 RL13
               end
            end
            L_TX: begin
               if (rise) begin
                  next_cnt = 4'(cnt + 4'h1);
               end else if (fall) begin
                  if (cnt == 4'h8) begin
                     next_sda_oe_n = 1'b1;
                     next_cnt = 4'h0;
                     next_st = L_RACK;
                  end else begin
                     next_shreg = {shreg[6:0], 1'b1};
                     next_sda_oe_n = shreg[6];
                  end
               end
            end
            L_RACK: begin
               if (cnt == 4'h0 && rise) begin
                  next_ack_seen = !f_sda;
                  next_cnt = 4'h1;
               end else if (cnt == 4'h1 && fall) begin
                  next_ev_tog = ~ev_tog;
                  next_st = L_WAIT;
                  if (!ack_seen) begin
                     next_lk_code = tws_pkg::CODE_TX_NACK; // RL4
                  end else if (final_byte) begin
                     next_lk_code = tws_pkg::CODE_LAST_ACK; // RL5
                  end else begin
                     next_lk_code = tws_pkg::CODE_TX_ACK; // RL3
                  end
                  // Ending the transfer leaves both lines free so the master reads ones
                  next_hold = ack_seen && !final_byte; // RL18 RL19
                  next_scl_oe_n = !(ack_seen && !final_byte);
                  next_txn = ack_seen && !final_byte;
               end
            end
            default: begin
               next_st = st;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         st <= L_IDLE;
         cnt <= 4'h0;
         shreg <= tws_pkg::DATA_RESET;
         lk_code <= tws_pkg::CODE_IDLE;
         p_scl <= 1'b1;
         p_sda <= 1'b1;
         hold <= 1'b0;
         final_byte <= 1'b0;
         txn <= 1'b0;
         ack_seen <= 1'b0;
         rel_seen <= 1'b0;
         ev_tog <= 1'b0;
         busy <= 1'b0;
         sda_oe_n <= 1'b1;
         scl_oe_n <= 1'b1;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         shreg <= next_shreg;
         lk_code <= next_lk_code;
         p_scl <= f_scl;
         p_sda <= f_sda;
         hold <= next_hold;
         final_byte <= next_final;
         txn <= next_txn;
         ack_seen <= next_ack_seen;
         rel_seen <= rel_s;
         ev_tog <= next_ev_tog;
         busy <= next_busy;
         sda_oe_n <= next_sda_oe_n;
         scl_oe_n <= next_scl_oe_n;
      end
   end

   assign scl_pin = '{out: 1'b0, oe_n: scl_oe_n};
   assign sda_pin = '{out: 1'b0, oe_n: sda_oe_n};

   a_stretch_low: assert property (@(posedge link_clk) disable iff (!lrst_n)
      hold |-> !scl_oe_n && st == L_WAIT) else $error("flag wait without stretch"); // RL19
   a_ignore_ones: assert property (@(posedge link_clk) disable iff (!lrst_n)
      st == L_WAIT && !hold |-> sda_oe_n && scl_oe_n) else $error("lines held after final byte"); // RL18
   a_error_release: assert property (@(posedge link_clk) disable iff (!lrst_n)
      en_l && (start_c || stop_c) && in_frame |=> sda_oe_n && scl_oe_n && lk_code == tws_pkg::CODE_BUS_ERROR)
      else $error("bus error not released"); // RL11 RL14
   a_ack_code: assert property (@(posedge link_clk) disable iff (!lrst_n)
      en_l && !start_c && !stop_c && st == L_RACK && cnt == 4'h1 && fall && ack_seen && !final_byte
      |=> lk_code == tws_pkg::CODE_TX_ACK ##1 !scl_oe_n) else $error("ack after byte code"); // RL3
   a_nack_code: assert property (@(posedge link_clk) disable iff (!lrst_n)
      en_l && !start_c && !stop_c && st == L_RACK && cnt == 4'h1 && fall && !ack_seen
      |=> lk_code == tws_pkg::CODE_TX_NACK) else $error("nack code"); // RL4
   a_last_ack: assert property (@(posedge link_clk) disable iff (!lrst_n)
      en_l && !start_c && !stop_c && st == L_RACK && cnt == 4'h1 && fall && ack_seen && final_byte
      |=> lk_code == tws_pkg::CODE_LAST_ACK) else $error("final byte ack code"); // RL5
   a_no_listen: assert property (@(posedge link_clk) disable iff (!lrst_n)
      en_l && !start_c && !stop_c && st == L_ADDR && rise && cnt == 4'h7 && !ack_l |=> st == L_IGNORE)
      else $error("address taken with ack disabled"); // RL7
   a_final_load: assert property (@(posedge link_clk) disable iff (!lrst_n)
      en_l && !start_c && !stop_c && st == L_WAIT && rel_ev && txn |=> st == L_TX && final_byte == !rel_ack)
      else $error("final byte choice"); // RL6
endmodule : tws_slave_tx

`default_nettype wire

// >>> sim/tws_master_model.sv
// Behavioural two-wire master receiver for the slave-transmitter bench.
// Assumes a pulled-up bus whose wired level comes back on scl_line and sda_line.
`timescale 1ns/1ps
`default_nettype none

module tws_master_model (
   // Clock
   input wire logic clk,
   // Wired bus levels
   input wire logic scl_line,
   input wire logic sda_line,
   // Open-drain drives, low pulls the line
   output logic scl_oe_n,
   output logic sda_oe_n
);
   initial begin
      scl_oe_n = 1'b1;
      sda_oe_n = 1'b1;
   end

   task automatic gap;
      repeat (3) @(posedge clk);
   endtask : gap

   // Bounded wait so a slave stuck stretching cannot hang the run
   task automatic scl_up;
      int n;
      n = 0;
      scl_oe_n <= 1'b1;
      gap();
      while (scl_line !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
   endtask : scl_up

   // SDA moves a clock after SCL fell, never on the same edge
   task automatic bit_out(input logic b);
      @(posedge clk);
      sda_oe_n <= b;
      gap();
      scl_up();
      gap();
      scl_oe_n <= 1'b0;
   endtask : bit_out

   task automatic bit_in(output logic b);
      @(posedge clk);
      sda_oe_n <= 1'b1;
      gap();
      scl_up();
      b = sda_line;
      gap();
      scl_oe_n <= 1'b0;
   endtask : bit_in

   // Entered with SCL low it is a repeated START; the bus stays ours
   task automatic start;
      @(posedge clk);
      sda_oe_n <= 1'b1;
      gap();
      scl_up();
      sda_oe_n <= 1'b0;
      gap();
      scl_oe_n <= 1'b0;
      gap();
   endtask : start

   task automatic stop;
      @(posedge clk);
      sda_oe_n <= 1'b0;
      gap();
      scl_up();
      sda_oe_n <= 1'b1;
      gap();
   endtask : stop

   task automatic write_byte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_out(v[i]);
      bit_in(b);
      ack = ~b;
   endtask : write_byte

   task automatic read_byte(input logic ack, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) bit_in(v[i]);
      bit_out(~ack);
   endtask : read_byte
endmodule : tws_master_model

`default_nettype wire

// >>> sim/tws_slave_tx_tb.sv
// Self-checking bench for the slave-transmitter status block against a model master.
// Assumes codes appear a few clk cycles after the SCL fall that ends each frame.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module tws_slave_tx_tb;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic nrst;
   logic ctrl_wr;
   tws_pkg::tws_ctrl_s ctrl_wdata;
   logic data_wr;
   logic [7:0] data_wdata;
   logic [6:0] own;
   logic arb_lost;
   logic master_active;
   tws_pkg::tws_ctrl_s ctrl_rd;
   logic [7:0] state_code_reg;
   logic write_collision;
   logic start_go;
   tws_pkg::tws_pin_s scl_pin;
   tws_pkg::tws_pin_s sda_pin;
   wire logic scl_line;
   wire logic sda_line;
   logic m_scl_oe_n;
   logic m_sda_oe_n;
   logic [7:0] exp_q[$];
   logic flag_q = 1'b0;
   logic ack;
   logic [7:0] d;
   logic [7:0] got;
   logic [7:0] note;
   int bad_count = 0;
   int n_checks = 0;
   int go_count = 0;
   int base;

   always #25 clk = ~clk;
   always #15 link_clk = ~link_clk;

   // Pulled-up open-drain lines
   assign scl_line = m_scl_oe_n & (scl_pin.oe_n | scl_pin.out);
   assign sda_line = m_sda_oe_n & (sda_pin.oe_n | sda_pin.out);

   tws_slave_tx uut (.clk(clk), .nrst(nrst), .link_clk(link_clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
      .data_wr(data_wr), .data_wdata(data_wdata), .own_slave_addr(own), .arb_lost(arb_lost),
      .master_active(master_active), .ctrl_rd(ctrl_rd), .state_code_reg(state_code_reg),
      .write_collision(write_collision), .start_go(start_go), .scl_in(scl_line), .scl_pin(scl_pin),
      .sda_in(sda_line), .sda_pin(sda_pin));

   tws_master_model m (.clk(clk), .scl_line(scl_line), .sda_line(sda_line), .scl_oe_n(m_scl_oe_n),
      .sda_oe_n(m_sda_oe_n));

   // Each rising flag consumes the oldest noted code
   always @(posedge clk) begin
      flag_q <= ctrl_rd.job_done_flag;
      if (start_go === 1'b1) go_count++;
      if (ctrl_rd.job_done_flag === 1'b1 && flag_q !== 1'b1) begin
         if (exp_q.size() == 0) `CHK("unexpected flag", 1'b1, 1'b0)
         else begin
            // One pop per flag; the compare macro reads its arguments twice
            note = exp_q.pop_front();
            `CHK("status code", state_code_reg & 8'hF8, note)
         end
      end
   end

   task automatic sw_ctrl(input logic f, input logic a, input logic s, input logic t, input logic g);
      @(posedge clk);
      ctrl_wdata <= '{f, a, s, t, 1'b1, g};
      ctrl_wr <= 1'b1;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      @(posedge clk);
      #1;
   endtask : sw_ctrl

   task automatic sw_data(input logic [7:0] v);
      @(posedge clk);
      data_wdata <= v;
      data_wr <= 1'b1;
      @(posedge clk);
      data_wr <= 1'b0;
      @(posedge clk);
      #1;
   endtask : sw_data

   task automatic wait_flag;
      int n;
      n = 0;
      while (ctrl_rd.job_done_flag !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK("flag raised", ctrl_rd.job_done_flag, 1'b1)
   endtask : wait_flag

   task automatic addr(input logic [7:0] a, input logic e);
      m.start();
      m.write_byte(a, ack);
      `CHK("address ack", ack, e)
   endtask : addr

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   initial begin
      #2000000;
      `CHK("watchdog", 1'b1, 1'b0)
      end_sim();
   end

   initial begin
      nrst <= 1'b0;
      ctrl_wr <= 1'b0;
      data_wr <= 1'b0;
      arb_lost <= 1'b0;
      master_active <= 1'b0;
      void'($urandom(25831));
      own <= 7'($urandom_range(127, 1));
      // Payloads are noise until a strobe qualifies them
      ctrl_wdata <= 6'($urandom);
      data_wdata <= 8'($urandom);
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      `CHK("idle code", state_code_reg, 8'hF8)
      `CHK("scl released", scl_pin.oe_n, 1'b1)
      sw_data(8'h5A);
      `CHK("collision set", write_collision, 1'b1)
      sw_ctrl(0, 1, 0, 0, 0);
      exp_q.push_back(8'hA8);
      addr({own, 1'b1}, 1'b1);
      wait_flag();
      `CHK("scl stretched", scl_pin.oe_n, 1'b0)
      exp_q.push_back(8'hB8);
      exp_q.push_back(8'hC0);
      for (int k = 1; k >= 0; k--) begin
         d = 8'($urandom);
         sw_data(d);
         `CHK("collision clear", write_collision, 1'b0)
         sw_ctrl(1, k[0], 0, 0, 0);
         `CHK("code while clear", state_code_reg, 8'hF8)
         m.read_byte(k[0], got);
         `CHK("byte seen", got, d)
         wait_flag();
      end
      // Leaving with acknowledge off isolates the slave
      sw_ctrl(1, 0, 0, 0, 0);
      m.stop();
      addr({own, 1'b1}, 1'b0);
      m.stop();
      sw_ctrl(0, 1, 0, 0, 0);
      addr({tws_pkg::GENERAL_CALL_ADDR, 1'b1}, 1'b0);
      m.stop();
      sw_ctrl(0, 1, 0, 0, 1);
      exp_q.push_back(8'hA8);
      addr({tws_pkg::GENERAL_CALL_ADDR, 1'b1}, 1'b1);
      wait_flag();
      d = 8'($urandom);
      sw_data(d);
      exp_q.push_back(8'hC8);
      sw_ctrl(1, 0, 0, 0, 1);
      m.read_byte(1'b1, got);
      `CHK("final byte", got, d)
      wait_flag();
      m.read_byte(1'b0, got);
      `CHK("ignored read", got, 8'hFF)
      base = go_count;
      @(posedge clk);
      master_active <= 1'b1;
      sw_ctrl(1, 1, 1, 0, 1);
      repeat (20) @(posedge clk);
      master_active <= 1'b0;
      #1;
      `CHK("repeated start go", go_count, base + 1)
      sw_ctrl(0, 1, 0, 0, 0);
      m.stop();
      @(posedge clk);
      arb_lost <= 1'b1;
      @(posedge clk);
      arb_lost <= 1'b0;
      exp_q.push_back(8'hB0);
      addr({own, 1'b1}, 1'b1);
      wait_flag();
      d = 8'($urandom);
      sw_data(d);
      exp_q.push_back(8'hC0);
      sw_ctrl(1, 0, 0, 0, 0);
      m.read_byte(1'b0, got);
      `CHK("lost arb byte", got, d)
      wait_flag();
      base = go_count;
      sw_ctrl(1, 1, 1, 0, 0);
      repeat (20) @(posedge clk);
      #1;
      `CHK("start held while busy", go_count, base)
      m.stop();
      repeat (40) @(posedge clk);
      #1;
      `CHK("start once bus free", go_count, base + 1)
      sw_ctrl(0, 1, 0, 0, 0);
      // START in the middle of an address byte
      m.start();
      exp_q.push_back(8'h00);
      for (int k = 0; k < 3; k++) m.bit_out(own[6 - k]);
      m.start();
      wait_flag();
      `CHK("lines released", {scl_pin.oe_n, sda_pin.oe_n}, 2'b11)
      sw_ctrl(1, 1, 0, 1, 0);
      `CHK("recovered ctrl", ctrl_rd, 6'b010010)
      m.stop();
      exp_q.push_back(8'hA8);
      addr({own, 1'b1}, 1'b1);
      wait_flag();
      repeat (2) @(posedge clk);
      `CHK("notes consumed", exp_q.size(), 0)
      end_sim();
   end
endmodule : tws_slave_tx_tb

`default_nettype wire
